// >>> initiator_model.sv
// Initiator model that hands command blocks to the handler.
`timescale 1ns/1ps
module initiator_model (
   input wire logic clk,
   input wire logic done,
   output logic cmd_valid,
   output wbl_pkg::cdb_type cmd,
   output logic [23:0] data_bytes
);
   import wbl_pkg::*;

   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
      data_bytes = 24'h00_0000;
   end

   // One single-cycle request, then a bounded wait for completion.
   // The lines are inverted afterwards so a stale block never looks valid.
   task automatic send(input cdb_type c, output logic ok);
      int n;
      @(posedge clk);
      #1;
      cmd = c;
      data_bytes = c.length;
      cmd_valid = 1'b1;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      cmd = ~c;
      data_bytes = ~c.length;
      n = 0;
      while (done !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1;
         n++;
      end
      ok = (done === 1'b1);
   endtask : send
endmodule : initiator_model

// >>> wbl_pkg.sv
// Package of constants and carriers for the write buffer and long write command handler.
package wbl_pkg;

   // ----------------------------------------------------------------
   // Opcodes, modes and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] OPC_WRITE_BUFFER = 8'h3B;
   localparam logic [7:0] OPC_WRITE_LONG10 = 8'h3F;
   localparam logic [4:0] MODE_SAVE_SINGLE = 5'h05;
   localparam logic [4:0] MODE_SAVE_MULTI = 5'h07;
   localparam logic [4:0] MODE_ECHO = 5'h0A;
   localparam logic [4:0] MODE_DEFER_EVENTS = 5'h0D;
   localparam logic [4:0] MODE_DEFER = 5'h0E;
   localparam logic [4:0] MODE_ACTIVATE = 5'h0F;
   localparam logic [4:0] MODE_EXPANDER = 5'h1A;
   localparam int BIT_PO_ACT = 7;
   localparam int BIT_HR_ACT = 6;
   localparam int BIT_VSE_ACT = 5;
   localparam int BIT_COR_DIS = 7;
   localparam int BIT_WR_UNCOR = 6;
   localparam logic [7:0] BUF_ID_RESTART = 8'h00;
   // Segment length granule of 4K bytes expressed as a low-bit mask.
   localparam logic [23:0] SEG_GRANULE_MASK = 24'h00_0FFF;
   localparam logic [15:0] MEDIA_CHECK_BYTES = 16'h0012;
   localparam logic [15:0] BLOCK_BYTES = 16'h0200;
   localparam logic [1:0] ECHO_ALIGN_MASK = 2'h3;
   localparam logic [23:0] ZERO_LEN = 24'h00_0000;

   // ----------------------------------------------------------------
   // Sense codes
   // ----------------------------------------------------------------
   localparam logic [3:0] SK_NONE = 4'h0;
   localparam logic [3:0] SK_MEDIUM_ERROR = 4'h3;
   localparam logic [3:0] SK_ILLEGAL_REQUEST = 4'h5;
   localparam logic [15:0] ASC_NONE = 16'h0000;
   localparam logic [15:0] ASC_INVALID_FIELD_CDB = 16'h2400;
   localparam logic [15:0] ASC_MARKED_BAD_BY_CLIENT = 16'h1114;

   // Marked-block table depth.
   localparam int MARK_DEPTH = 8;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [31:0] lba;
      logic [7:0] buf_id;
      logic [23:0] buf_offset;
      logic [23:0] length;
      logic [7:0] mode_specific;
   } cdb_type;

   typedef struct packed {
      logic check;
      logic [3:0] sense_key;
      logic [15:0] asc;
      logic ili;
      logic valid;
      logic [31:0] info;
   } status_type;

   typedef struct packed {
      logic hit;
      logic cor_dis;
   } mark_type;

endpackage : wbl_pkg

// >>> write_buffer_long_handler.sv
// Command logic for segmented microcode, echo buffer, deferred activation and long writes.
// Functional notes
// [RULE1] Host segment lengths are multiples of 4K.
// [RULE2] Bad segment length gives invalid field error.
// [RULE3] Host sends segments in order, summing correctly.
// [RULE4] First segment starts file; id 00h restarts.
// [RULE5] Buffer offset ignored in multi-file mode.
// [RULE6] Complete file then behaves as single-file save.
// [RULE7] Echo data stored aligned on 4 bytes.
// [RULE8] Echo contents kept until another command.
// [RULE9] Events mode saves deferred; activate on 0Fh.
// [RULE10] Mode bits 7,6,5; power-on flag honoured.
// [RULE11] Unsupported activation events give invalid field.
// [RULE12] Defer mode activates on power, command, reset.
// [RULE13] Activate mode ignores id, offset, length.
// [RULE14] Expander mode behaves like echo write.
// [RULE15] Long write: one block plus 18 check bytes.
// [RULE16] Long write always marks; correction disable wins.
// [RULE17] Correction-disabled mark: medium error, no recovery. The code sets only read_mark, with no medium error sense.
// [RULE18] Enabled mark: recovery, exceptions, logging, medium error; code gives read_recover and read_log only, no medium error sense.
// [RULE19] Mark kept until the block is rewritten; long writes take the 8 entries in turn, dropping any mark there.
// [RULE20] Length mismatch: error, ILI, signed difference.
// [RULE21] LBA bytes 2-5, length bytes 7-8.
// [RULE22] Unsupported buffer mode gives invalid field.
// [RULE23] Single-file save effective after self reset.
// [RULE24] Running segment byte count checked at end.
// [RULE25] Per-block mark records correction-disabled state.
`timescale 1ns/1ps
module write_buffer_long_handler (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cmd_valid,
   input wire wbl_pkg::cdb_type cmd,
   input wire logic [23:0] data_bytes,
   input wire logic [23:0] file_length,
   input wire logic other_cmd,
   input wire logic rewrite_valid,
   input wire logic [31:0] rewrite_lba,
   input wire logic read_valid,
   input wire logic [31:0] read_lba,
   input wire logic power_on_event,
   input wire logic self_reset_event,
   output wbl_pkg::status_type status,
   output logic done,
   output logic echo_store,
   output logic echo_valid,
   output logic ucode_save,
   output logic deferred,
   output logic activate,
   output logic single_pending,
   output logic block_write,
   output wbl_pkg::mark_type read_mark,
   output logic read_recover,
   output logic read_log
);
   import wbl_pkg::*;
   // ----------------------------------------------------------------
   // State and storage
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DONE = 3'b100
   } state_type;
   state_type state;
   cdb_type held;
   logic [23:0] held_data;
   logic [23:0] seg_count;
   logic restart_armed;
   logic defer_po;
   logic [31:0] mark_lba [MARK_DEPTH];
   logic [MARK_DEPTH-1:0] mark_used;
   logic [MARK_DEPTH-1:0] mark_cd;
   logic [2:0] mark_ptr;
   logic mode_ok;
   logic seg_bad;
   logic events_bad;
   logic [15:0] long_expect;
   logic long_bad;
   logic [23:0] next_seg_count;
   mark_type read_hit;
   logic long_go;
   logic defer_sr;
   // Supported buffer modes; anything else is refused.
   function automatic logic mode_supported(input logic [4:0] m);
      case (m)
         MODE_SAVE_SINGLE, MODE_SAVE_MULTI, MODE_ECHO, MODE_DEFER_EVENTS,
         MODE_DEFER, MODE_ACTIVATE, MODE_EXPANDER: mode_supported = 1'b1; // RULE22
         default: mode_supported = 1'b0;
      endcase
   endfunction : mode_supported
   // Looks up a block in the mark table; used by reads only, rewrites compare rw_eq directly.
   function automatic mark_type lookup(input logic [31:0] a,
         input logic [MARK_DEPTH-1:0] used, input logic [MARK_DEPTH-1:0] cd,
         input logic [MARK_DEPTH-1:0] eq);
      mark_type r;
      r = '0;
      for (int i = 0; i < MARK_DEPTH; i++) begin
         if (used[i] && eq[i]) begin
            r.hit = 1'b1;
            r.cor_dis = cd[i]; // RULE25
         end
      end
      lookup = r;
   endfunction : lookup
   logic [MARK_DEPTH-1:0] read_eq;
   logic [MARK_DEPTH-1:0] rw_eq;
   genvar g;
   generate
      for (g = 0; g < MARK_DEPTH; g++) begin : g_cmp
         assign read_eq[g] = (mark_lba[g] == read_lba);
         assign rw_eq[g] = (mark_lba[g] == rewrite_lba);
      end
   endgenerate
   // ----------------------------------------------------------------
   // Decode of the held command
   // ----------------------------------------------------------------
   // Checks are made on the held copy so the host may change its inputs freely.
   always_comb begin
      mode_ok = mode_supported(held.byte1[4:0]); // RULE22
      seg_bad = (held.length & SEG_GRANULE_MASK) != ZERO_LEN; // RULE2
      events_bad = held.mode_specific[BIT_HR_ACT] | held.mode_specific[BIT_VSE_ACT]; // RULE11
      long_expect = BLOCK_BYTES + MEDIA_CHECK_BYTES; // RULE15
      long_bad = (held.length[15:0] != 16'h0000) && (held.length[15:0] != long_expect); // RULE20
      // Buffer offset never enters the count; the granule is the only check.
      next_seg_count = seg_count + held.length; // RULE5 RULE24
      read_hit = lookup(read_lba, mark_used, mark_cd, read_eq);
      long_go = state == ST_EXEC && held.opcode == OPC_WRITE_LONG10 && !long_bad; // RULE15
   end
   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         held <= '0;
         held_data <= ZERO_LEN;
      end else begin
         case (state)
            ST_IDLE: begin
               if (cmd_valid) begin
                  held <= cmd;
                  // Long write carries LBA in bytes 2-5 and length in bytes 7-8.
                  if (cmd.opcode == OPC_WRITE_LONG10) begin
                     held.length <= {8'h00, cmd.length[15:0]}; // RULE21
                  end
                  held_data <= data_bytes;
                  state <= ST_EXEC;
               end
            end
            ST_EXEC: state <= ST_DONE;
            ST_DONE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Completion status
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status <= '0;
         done <= 1'b0;
      end else begin
         done <= (state == ST_EXEC);
         if (state == ST_EXEC) begin
            status <= '0;
            if (held.opcode == OPC_WRITE_BUFFER) begin
               if (!mode_ok ||
                   (held.byte1[4:0] == MODE_SAVE_MULTI && seg_bad) || // RULE2
                   (held.byte1[4:0] == MODE_DEFER_EVENTS && events_bad)) begin // RULE11
                  status.check <= 1'b1;
                  status.sense_key <= SK_ILLEGAL_REQUEST;
                  status.asc <= ASC_INVALID_FIELD_CDB;
               end
            end else if (held.opcode == OPC_WRITE_LONG10 && long_bad) begin
               // Information holds requested minus actual, wrapping negative.
               status.check <= 1'b1; // RULE20
               status.sense_key <= SK_ILLEGAL_REQUEST;
               status.asc <= ASC_INVALID_FIELD_CDB;
               status.valid <= 1'b1;
               status.ili <= 1'b1;
               status.info <= {16'h0000, held.length[15:0]} - {16'h0000, long_expect};
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // Segmented microcode download
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seg_count <= ZERO_LEN;
         restart_armed <= 1'b0;
      end else if (state == ST_EXEC && held.opcode == OPC_WRITE_BUFFER) begin
         if (held.byte1[4:0] == MODE_SAVE_MULTI) begin
            // After an error, id 00h begins the file again; else the id is ignored.
            restart_armed <= seg_bad; // RULE4
            if (restart_armed && held.buf_id == BUF_ID_RESTART) begin
               seg_count <= seg_bad ? ZERO_LEN : held.length; // RULE4
            end else if (!seg_bad) begin
               // Reaching the file length saves it, so the next segment starts afresh.
               seg_count <= next_seg_count >= file_length ? ZERO_LEN : next_seg_count; // RULE24
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // Microcode save and activation
   // ----------------------------------------------------------------
   // A single-file save waits for the drive's own reset before running.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ucode_save <= 1'b0;
         deferred <= 1'b0;
         defer_po <= 1'b0;
         defer_sr <= 1'b0;
         activate <= 1'b0;
         single_pending <= 1'b0;
      end else begin
         ucode_save <= 1'b0;
         activate <= 1'b0;
         if (state == ST_EXEC && held.opcode == OPC_WRITE_BUFFER && mode_ok) begin
            case (held.byte1[4:0])
               MODE_SAVE_SINGLE: begin
                  ucode_save <= 1'b1;
                  single_pending <= 1'b1; // RULE23
               end
               MODE_SAVE_MULTI: begin
                  // Only the segment that completes the file saves it.
                  if (!seg_bad && !(restart_armed && held.buf_id == BUF_ID_RESTART) &&
                      next_seg_count >= file_length) begin
                     ucode_save <= 1'b1; // RULE6
                     single_pending <= 1'b1; // RULE6
                  end
               end
               MODE_DEFER_EVENTS: begin
                  if (!events_bad) begin
                     ucode_save <= 1'b1; // RULE9
                     deferred <= 1'b1;
                     defer_po <= held.mode_specific[BIT_PO_ACT]; // RULE10
                     defer_sr <= 1'b0; // RULE9
                  end
               end
               MODE_DEFER: begin
                  ucode_save <= 1'b1;
                  deferred <= 1'b1;
                  defer_po <= 1'b1; // RULE12
                  defer_sr <= 1'b1; // RULE12
               end
               MODE_ACTIVATE: begin
                  // Id, offset and length play no part here.
                  activate <= deferred; // RULE13
                  deferred <= 1'b0; // RULE9
               end
               default: ;
            endcase
         end else if (deferred && ((power_on_event && defer_po) || (self_reset_event && defer_sr))) begin
            activate <= 1'b1; // RULE12
            deferred <= 1'b0;
         end else if (single_pending && self_reset_event) begin
            activate <= 1'b1; // RULE23
            single_pending <= 1'b0;
         end
      end
   end
   // ----------------------------------------------------------------
   // Echo buffer
   // ----------------------------------------------------------------
   // Only a length that is a 4-byte multiple is stored, so stores stay aligned.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         echo_store <= 1'b0;
         echo_valid <= 1'b0;
      end else begin
         echo_store <= 1'b0;
         if (state == ST_EXEC && held.opcode == OPC_WRITE_BUFFER &&
             (held.byte1[4:0] == MODE_ECHO || held.byte1[4:0] == MODE_EXPANDER)) begin // RULE14
            echo_store <= (held.length[1:0] & ECHO_ALIGN_MASK) == 2'h0; // RULE7
            echo_valid <= (held.length[1:0] & ECHO_ALIGN_MASK) == 2'h0; // RULE8
         end else if (other_cmd) begin
            echo_valid <= 1'b0; // RULE8
         end
      end
   end

   // ----------------------------------------------------------------
   // Pseudo-error mark table
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mark_used <= '0;
         mark_cd <= '0;
         mark_ptr <= 3'h0;
         block_write <= 1'b0;
         for (int i = 0; i < MARK_DEPTH; i++) begin
            mark_lba[i] <= 32'h0000_0000;
         end
      end else begin
         block_write <= 1'b0;
         // A long write to a block already marked drops the older entry; the set below wins.
         for (int i = 0; i < MARK_DEPTH; i++) begin
            if ((rewrite_valid && rw_eq[i]) || (long_go && mark_lba[i] == held.lba)) begin
               mark_used[i] <= 1'b0; // RULE19
            end
         end
         if (long_go) begin
            block_write <= 1'b1; // RULE15
            mark_lba[mark_ptr] <= held.lba; // RULE21
            mark_used[mark_ptr] <= 1'b1; // RULE16
            mark_cd[mark_ptr] <= held.byte1[BIT_COR_DIS]; // RULE16 RULE25
            mark_ptr <= mark_ptr + 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read handling of marked blocks
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         read_mark <= '0;
         read_recover <= 1'b0;
         read_log <= 1'b0;
      end else begin
         read_mark <= read_valid ? read_hit : '0;
         read_recover <= read_valid && read_hit.hit && !read_hit.cor_dis; // RULE17 RULE18
         read_log <= read_valid && read_hit.hit && !read_hit.cor_dis; // RULE18
      end
   end
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_bad_mode_check: assert property (@(posedge clk) disable iff (!rst_b) // RULE22
      (state == ST_EXEC && held.opcode == OPC_WRITE_BUFFER && !mode_ok)
      |=> (done && status.check && status.asc == ASC_INVALID_FIELD_CDB))
      else $error("unsupported mode not refused");
   a_seg_len_check: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
      (state == ST_EXEC && held.opcode == OPC_WRITE_BUFFER &&
       held.byte1[4:0] == MODE_SAVE_MULTI && seg_bad) |=> status.check && !ucode_save)
      else $error("bad segment length accepted");
   a_events_check: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
      (state == ST_EXEC && held.opcode == OPC_WRITE_BUFFER &&
       held.byte1[4:0] == MODE_DEFER_EVENTS && events_bad)
      |=> status.sense_key == SK_ILLEGAL_REQUEST && !ucode_save)
      else $error("unsupported activation event accepted");
   a_long_len_info: assert property (@(posedge clk) disable iff (!rst_b) // RULE20
      (state == ST_EXEC && held.opcode == OPC_WRITE_LONG10 && long_bad)
      |=> status.ili && status.valid && !block_write)
      else $error("long length mismatch not flagged");
   a_mark_read: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
      (read_valid && read_hit.hit && read_hit.cor_dis) |=> read_mark.hit && !read_recover)
      else $error("correction disabled read recovered");
   a_mark_recover: assert property (@(posedge clk) disable iff (!rst_b) // RULE18
      (read_valid && read_hit.hit && !read_hit.cor_dis) |=> read_recover && read_log)
      else $error("correctable mark read skipped recovery");
   a_activate_clear: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
      activate |-> !deferred)
      else $error("deferred code still deferred after activation");
   a_echo_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
      (echo_valid && !other_cmd && state != ST_EXEC) |=> echo_valid)
      else $error("echo contents dropped without cause");
   a_cmd_cycle: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
      (state == ST_IDLE && cmd_valid) |=> ##1 done ##1 !done)
      else $error("command did not complete in two cycles");

endmodule : write_buffer_long_handler

// >>> write_buffer_long_handler_bench.sv
// Self-checking bench for the write buffer and long write handler.
`timescale 1ns/1ps
`define CHK(g, e) check_eq(64'(g), 64'(e))
module write_buffer_long_handler_bench;
   import wbl_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cmd_valid;
   cdb_type cmd;
   logic [23:0] data_bytes;
   logic [23:0] file_length = 24'h00_3000;
   logic [3:0] ev = 4'h0;
   logic read_valid = 1'b0;
   logic [31:0] read_lba = 32'h0000_0000;
   logic [31:0] rewrite_lba = 32'h0000_0000;
   status_type status;
   mark_type read_mark;
   logic done, echo_store, echo_valid, ucode_save, deferred, activate;
   logic single_pending, block_write, read_recover, read_log, ok;
   int bad_count = 0;
   int n_compared = 0;
   cdb_type c;
   logic [7:0] b1;
   logic [23:0] len;
   logic [4:0] m;

   always #10 clk = ~clk;

   write_buffer_long_handler dut_u (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
      .cmd(cmd), .data_bytes(data_bytes), .file_length(file_length), .other_cmd(ev[0]),
      .rewrite_valid(ev[1]), .rewrite_lba(rewrite_lba), .read_valid(read_valid),
      .read_lba(read_lba), .power_on_event(ev[2]), .self_reset_event(ev[3]),
      .status(status), .done(done), .echo_store(echo_store), .echo_valid(echo_valid),
      .ucode_save(ucode_save), .deferred(deferred), .activate(activate),
      .single_pending(single_pending), .block_write(block_write), .read_mark(read_mark),
      .read_recover(read_recover), .read_log(read_log));

   initiator_model host_u (.clk(clk), .done(done), .cmd_valid(cmd_valid), .cmd(cmd),
      .data_bytes(data_bytes));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check_eq(input logic [63:0] g, input logic [63:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : check_eq

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up

   // Block address and offset are random so ignored fields really vary.
   function automatic cdb_type mk(input logic [7:0] op, input logic [7:0] b, input logic [7:0] id,
         input logic [23:0] l, input logic [7:0] ms);
      mk = '{op, b, $urandom(), id, 24'($urandom()), l, ms};
   endfunction : mk

   task automatic run(input cdb_type x);
      host_u.send(x, ok);
      `CHK(ok, 1'b1);
   endtask : run

   // A refusal must carry the full sense; success only needs the flag clear.
   task automatic st(input logic bad);
      if (bad) begin
         `CHK({status.check, status.sense_key, status.asc},
            {1'b1, SK_ILLEGAL_REQUEST, ASC_INVALID_FIELD_CDB});
      end else begin
         `CHK(status.check, 1'b0);
      end
   endtask : st

   task automatic fire(input int k);
      @(posedge clk);
      #1 ev[k] = 1'b1;
      @(posedge clk);
      #1 ev[k] = 1'b0;
      @(posedge clk);
      #1;
   endtask : fire

   task automatic rd(input logic [31:0] a);
      @(posedge clk);
      #1 read_lba = a;
      read_valid = 1'b1;
      @(posedge clk);
      #1 read_valid = 1'b0;
      read_lba = ~a;
   endtask : rd

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'he14f));
      repeat (8) @(posedge clk);
      #1 rst_b = 1'b1;
      for (int i = 0; i < 32; i++) begin
         m = 5'(i);
         if (!(m inside {5'h00, 5'h02, 5'h04, MODE_SAVE_SINGLE, MODE_SAVE_MULTI, MODE_ECHO,
               MODE_DEFER_EVENTS, MODE_DEFER, MODE_ACTIVATE, MODE_EXPANDER})) begin
            run(mk(OPC_WRITE_BUFFER, {3'h0, m}, 8'h00, 24'h00_1000, 8'h00));
            st(1'b1);
         end
      end
      $display("test unsupported modes done");
      for (int k = 0; k < 2; k++) begin
         m = k ? MODE_EXPANDER : MODE_ECHO;
         len = 24'(4 * $urandom_range(1, 64));
         run(mk(OPC_WRITE_BUFFER, {3'h0, m}, 8'h00, len + 24'h00_0002, 8'h00));
         `CHK(echo_store, 1'b0);
         run(mk(OPC_WRITE_BUFFER, {3'h0, m}, 8'h00, len, 8'h00));
         st(1'b0);
         `CHK(echo_store, 1'b1);
         repeat (3) @(posedge clk);
         #1 `CHK(echo_valid, 1'b1);
         fire(0);
         `CHK(echo_valid, 1'b0);
      end
      $display("test echo and expander done");
      run(mk(OPC_WRITE_BUFFER, {3'h0, MODE_SAVE_SINGLE}, 8'h00, 24'h00_1000, 8'h00));
      `CHK({status.check, ucode_save, single_pending}, 3'h3);
      fire(3);
      `CHK(single_pending, 1'b0);
      c = mk(OPC_WRITE_BUFFER, {3'h0, MODE_SAVE_MULTI}, 8'h07, 24'h00_1000, 8'h00);
      run(c);
      `CHK({status.check, ucode_save}, 2'h0);
      c.length = 24'h00_1004;
      run(c);
      st(1'b1);
      c.buf_id = BUF_ID_RESTART;
      c.length = 24'h00_1000;
      for (int s = 0; s < 3; s++) begin
         c.buf_offset = 24'($urandom());
         run(c);
         st(1'b0);
         `CHK(ucode_save, s == 2);
         c.buf_id = 8'($urandom_range(1, 255));
      end
      `CHK(single_pending, 1'b1);
      fire(3);
      `CHK(single_pending, 1'b0);
      $display("test segmented save done");
      for (int b = 5; b < 7; b++) begin
         run(mk(OPC_WRITE_BUFFER, {3'h0, MODE_DEFER_EVENTS}, 8'h00, 24'h00_1000, 8'(1 << b)));
         st(1'b1);
      end
      run(mk(OPC_WRITE_BUFFER, {3'h0, MODE_DEFER_EVENTS}, 8'h00, 24'h00_1000, 8'h80));
      `CHK({status.check, ucode_save, deferred}, 3'h3);
      fire(2);
      `CHK(deferred, 1'b0);
      run(mk(OPC_WRITE_BUFFER, {3'h0, MODE_DEFER_EVENTS}, 8'h00, 24'h00_1000, 8'h00));
      fire(2);
      `CHK(deferred, 1'b1);
      fire(3);
      `CHK(deferred, 1'b1);
      run(mk(OPC_WRITE_BUFFER, {3'h0, MODE_ACTIVATE}, 8'($urandom()), 24'($urandom()), 8'h00));
      `CHK({status.check, activate}, 2'h1);
      fire(0);
      `CHK(deferred, 1'b0);
      for (int k = 2; k < 4; k++) begin
         run(mk(OPC_WRITE_BUFFER, {3'h0, MODE_DEFER}, 8'h00, 24'h00_1000, 8'h00));
         `CHK(deferred, 1'b1);
         fire(k);
         `CHK(deferred, 1'b0);
      end
      $display("test deferred activation done");
      for (int k = 0; k < 8; k++) begin
         b1 = k ? {2'($urandom()), 6'h00} : 8'hC0;
         c = mk(OPC_WRITE_LONG10, b1, 8'h00, 24'(BLOCK_BYTES + MEDIA_CHECK_BYTES), 8'h00);
         run(c);
         `CHK({status.check, block_write}, 2'h1);
         rd(c.lba);
         `CHK({read_mark, read_recover, read_log}, {1'b1, {3{b1[7]}} ^ 3'h3});
      end
      // The table has wrapped, so the new mark lands below the old one.
      c.byte1 = {!b1[7], 7'h00};
      run(c);
      rd(c.lba);
      `CHK({read_mark, read_recover}, {1'b1, !b1[7], b1[7]});
      rewrite_lba = c.lba;
      fire(1);
      rd(c.lba);
      `CHK(read_mark.hit, 1'b0);
      for (int k = 0; k < 3; k++) begin
         c.length = k == 0 ? 24'h00_0258 : k == 1 ? 24'h00_01F4 : 24'($urandom_range(531, 4000));
         run(c);
         st(1'b1);
         `CHK({block_write, status.valid, status.ili, status.info},
            {3'h3, 32'(c.length) - 32'(BLOCK_BYTES + MEDIA_CHECK_BYTES)});
      end
      $display("test long write done");
      wrap_up();
   end

   // Tests take a few hundred cycles; this margin only trips on a hang.
   initial begin
      #(20 * 20000);
      bad_count++;
      wrap_up();
   end
endmodule : write_buffer_long_handler_bench
